// ---- pecg_pkg.sv ----
//------------------------------------------------------------
// peripheral enable and clock gate constants
//------------------------------------------------------------
package pecg_pkg;

  // register byte addresses
  localparam logic [31:0] PE1_ADDR = 32'h4000_0028;
  localparam logic [31:0] PE2_ADDR = 32'h4000_002c;
  localparam logic [31:0] PCG1_ADDR = 32'h4000_0030;

  // group one bit positions (enable and clock gate share them)
  localparam int unsigned TMR0_BIT  = 16;
  localparam int unsigned TMR1_BIT  = 17;
  localparam int unsigned TMR2_BIT  = 18;
  localparam int unsigned TMR3_BIT  = 19;
  localparam int unsigned TMR8_BIT  = 24;
  localparam int unsigned TMR9_BIT  = 25;
  localparam int unsigned IOA_BIT   = 8;
  localparam int unsigned IOB_BIT   = 9;
  localparam int unsigned IOC_BIT   = 10;
  localparam int unsigned IOD_BIT   = 11;
  localparam int unsigned DMA_BIT   = 4;

  // group two bit positions
  localparam int unsigned SSP_BIT   = 0;
  localparam int unsigned TWP_BIT   = 4;
  localparam int unsigned SER0_BIT  = 8;
  localparam int unsigned SER1_BIT  = 9;
  localparam int unsigned MPU_BIT   = 16;
  localparam int unsigned CNV0_BIT  = 20;
  localparam int unsigned CNV1_BIT  = 21;

  // writable masks, read-only ones and reset values
  localparam logic [31:0] GRP1_RW_MASK = 32'h030f_0f10;
  localparam logic [31:0] GRP1_RO_ONES = 32'h0000_000f;
  localparam logic [31:0] GRP1_RESET   = 32'h0000_000f;
  localparam logic [31:0] GRP2_RW_MASK = 32'h0031_0311;
  localparam logic [31:0] GRP2_RO_ONES = 32'h0000_0000;
  localparam logic [31:0] GRP2_RESET   = 32'h0000_0101;

endpackage

// ---- pecg_field_reg.sv ----
`timescale 1ns/1ps
`default_nettype none
module pecg_field_reg #(
  parameter logic [31:0] RW_MASK = 32'h0000_0000,
  parameter logic [31:0] RO_ONES = 32'h0000_0000,
  parameter logic [31:0] RESET   = 32'h0000_0000
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // write port
  input  wire logic        wrEn,
  input  wire logic [31:0] wrData,
  // stored value
  output var  logic [31:0] value
);

  logic [31:0] next_value;

  // reserved bits never store; read-only bits are constant
  always_comb begin
    next_value = value;
    if (wrEn) begin
      next_value = (wrData & RW_MASK) | RO_ONES;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      value <= RESET;
    end else begin
      value <= next_value;
    end
  end

endmodule
`default_nettype wire

// ---- pecg_top.sv ----
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pecg_top (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // group one reset releases, low holds in reset
  output var  logic [5:0]  timerRstN,
  output var  logic [3:0]  ioPortRstN,
  output var  logic        dmaRstN,
  // group two reset releases, low holds in reset
  output var  logic        syncSerialRstN,
  output var  logic        twoWireRstN,
  output var  logic [1:0]  serialRstN,
  output var  logic        motorPulseRstN,
  output var  logic [1:0]  converterRstN,
  // group one clock enables
  output var  logic [5:0]  timerClkEn,
  output var  logic [3:0]  ioPortClkEn,
  output var  logic        dmaClkEn
);

  //----------------------------------------------------------
  // bus decode
  //----------------------------------------------------------
  logic        hitPe1;
  logic        hitPe2;
  logic        hitPcg1;
  logic        hitAny;
  logic        setupPh;
  logic        wrDone;
  logic [31:0] pe1;
  logic [31:0] pe2;
  logic [31:0] pcg1;

  always_comb begin
    hitPe1  = (paddr == pecg_pkg::PE1_ADDR);
    hitPe2  = (paddr == pecg_pkg::PE2_ADDR);
    hitPcg1 = (paddr == pecg_pkg::PCG1_ADDR);
    hitAny  = hitPe1 | hitPe2 | hitPcg1;
    setupPh = psel & ~penable;
    // write lands only on the completing access edge
    wrDone  = psel & penable & pready & pwrite & hitAny;
  end

  //----------------------------------------------------------
  // apb response, no wait state, every output is a flop
  //----------------------------------------------------------
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (setupPh) begin
      next_pready  = 1'b1;
      next_pslverr = ~hitAny;
      if (!pwrite) begin
        if (hitPe1) begin
          next_prdata = pe1;
        end else if (hitPe2) begin
          next_prdata = pe2;
        end else if (hitPcg1) begin
          next_prdata = pcg1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  //----------------------------------------------------------
  // control registers
  //----------------------------------------------------------
  pecg_field_reg #(
    .RW_MASK (pecg_pkg::GRP1_RW_MASK),
    .RO_ONES (pecg_pkg::GRP1_RO_ONES),
    .RESET   (pecg_pkg::GRP1_RESET)
  ) uEnable1 (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .wrEn    (wrDone & hitPe1),
    .wrData  (pwdata),
    .value   (pe1)
  );

  pecg_field_reg #(
    .RW_MASK (pecg_pkg::GRP2_RW_MASK),
    .RO_ONES (pecg_pkg::GRP2_RO_ONES),
    .RESET   (pecg_pkg::GRP2_RESET)
  ) uEnable2 (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .wrEn    (wrDone & hitPe2),
    .wrData  (pwdata),
    .value   (pe2)
  );

  pecg_field_reg #(
    .RW_MASK (pecg_pkg::GRP1_RW_MASK),
    .RO_ONES (pecg_pkg::GRP1_RO_ONES),
    .RESET   (pecg_pkg::GRP1_RESET)
  ) uClkGate1 (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .wrEn    (wrDone & hitPcg1),
    .wrData  (pwdata),
    .value   (pcg1)
  );

  //----------------------------------------------------------
  // output stage
  //----------------------------------------------------------
  // one flop per output keeps peripheral resets glitch free,
  // at the cost of one cycle of latency after the write
  logic [5:0] next_timerRstN;
  logic [3:0] next_ioPortRstN;
  logic       next_dmaRstN;
  logic       next_syncSerialRstN;
  logic       next_twoWireRstN;
  logic [1:0] next_serialRstN;
  logic       next_motorPulseRstN;
  logic [1:0] next_converterRstN;
  logic [5:0] next_timerClkEn;
  logic [3:0] next_ioPortClkEn;
  logic       next_dmaClkEn;

  always_comb begin
    // set bit releases, clear bit holds in reset
    next_timerRstN = {pe1[pecg_pkg::TMR9_BIT], pe1[pecg_pkg::TMR8_BIT],
                      pe1[pecg_pkg::TMR3_BIT], pe1[pecg_pkg::TMR2_BIT],
                      pe1[pecg_pkg::TMR1_BIT],
                      pe1[pecg_pkg::TMR0_BIT]};
    next_ioPortRstN = {pe1[pecg_pkg::IOD_BIT], pe1[pecg_pkg::IOC_BIT],
                       pe1[pecg_pkg::IOB_BIT], pe1[pecg_pkg::IOA_BIT]};
    next_dmaRstN        = pe1[pecg_pkg::DMA_BIT];
    next_syncSerialRstN = pe2[pecg_pkg::SSP_BIT];
    next_twoWireRstN    = pe2[pecg_pkg::TWP_BIT];
    next_serialRstN     = {pe2[pecg_pkg::SER1_BIT],
                           pe2[pecg_pkg::SER0_BIT]};
    next_motorPulseRstN = pe2[pecg_pkg::MPU_BIT];
    next_converterRstN  = {pe2[pecg_pkg::CNV1_BIT],
                           pe2[pecg_pkg::CNV0_BIT]};
    next_timerClkEn = {pcg1[pecg_pkg::TMR9_BIT], pcg1[pecg_pkg::TMR8_BIT],
                       pcg1[pecg_pkg::TMR3_BIT], pcg1[pecg_pkg::TMR2_BIT],
                       pcg1[pecg_pkg::TMR1_BIT],
                       pcg1[pecg_pkg::TMR0_BIT]};
    next_ioPortClkEn = {pcg1[pecg_pkg::IOD_BIT], pcg1[pecg_pkg::IOC_BIT],
                        pcg1[pecg_pkg::IOB_BIT], pcg1[pecg_pkg::IOA_BIT]};
    next_dmaClkEn    = pcg1[pecg_pkg::DMA_BIT];
  end

  // reset values mirror the register reset values
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timerRstN      <= 6'h00;
      ioPortRstN     <= 4'h0;
      dmaRstN        <= 1'b0;
      // taken from the group two reset word so the two cannot drift
      syncSerialRstN <= pecg_pkg::GRP2_RESET[pecg_pkg::SSP_BIT];
      twoWireRstN    <= 1'b0;
      serialRstN     <= {pecg_pkg::GRP2_RESET[pecg_pkg::SER1_BIT],
                         pecg_pkg::GRP2_RESET[pecg_pkg::SER0_BIT]};
      motorPulseRstN <= 1'b0;
      converterRstN  <= 2'h0;
      timerClkEn     <= 6'h00;
      ioPortClkEn    <= 4'h0;
      dmaClkEn       <= 1'b0;
    end else begin
      timerRstN      <= next_timerRstN;
      ioPortRstN     <= next_ioPortRstN;
      dmaRstN        <= next_dmaRstN;
      syncSerialRstN <= next_syncSerialRstN;
      twoWireRstN    <= next_twoWireRstN;
      serialRstN     <= next_serialRstN;
      motorPulseRstN <= next_motorPulseRstN;
      converterRstN  <= next_converterRstN;
      timerClkEn     <= next_timerClkEn;
      ioPortClkEn    <= next_ioPortClkEn;
      dmaClkEn       <= next_dmaClkEn;
    end
  end

  //----------------------------------------------------------
  // checks
  //----------------------------------------------------------
  logic afterFirst;
  logic next_afterFirst;

  always_comb begin
    next_afterFirst = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      afterFirst <= 1'b0;
    end else begin
      afterFirst <= next_afterFirst;
    end
  end

  sequence wrPe1Tmr0(logic v);
    wrDone && hitPe1 && (pwdata[pecg_pkg::TMR0_BIT] == v);
  endsequence

  sequence wrPcg1Dma(logic v);
    wrDone && hitPcg1 && (pwdata[pecg_pkg::DMA_BIT] == v);
  endsequence

  release_on_one_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    wrPe1Tmr0(1'b1) |-> ##2 timerRstN[0])
    else $error("timer 0 not released after enable write");

  hold_in_reset_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !pe2[pecg_pkg::CNV0_BIT] [*2] |-> !converterRstN[0])
    else $error("converter 0 left reset while disabled");

  reset_on_zero_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    wrPe1Tmr0(1'b0) |-> ##2 !timerRstN[0])
    else $error("timer 0 not reset after zero write");

  clock_on_one_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    wrPcg1Dma(1'b1) |-> ##2 dmaClkEn)
    else $error("dma clock not enabled after one write");

  clock_off_zero_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    wrPcg1Dma(1'b0) |-> ##2 !dmaClkEn)
    else $error("dma clock not stopped after zero write");

  ro_bits_one_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    setupPh && !pwrite && (hitPe1 || hitPcg1)
    |=> pready && (prdata[3:0] == 4'hf) && !pslverr)
    else $error("read-only low bits of group one not one");

  group2_map_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    wrDone && hitPe2 && (pwdata == 32'h0030_0200)
    |-> ##2 (converterRstN == 2'h3) && (serialRstN == 2'h2)
         && !syncSerialRstN && !motorPulseRstN && !twoWireRstN)
    else $error("group two enable bit map wrong");

  reset_values_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !afterFirst |-> (pe2 == 32'h0000_0101) && syncSerialRstN
                 && (serialRstN == 2'h1) && !motorPulseRstN)
    else $error("group two reset value wrong");

  change_after_write_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    afterFirst && $changed(timerClkEn) |-> $past(wrDone && hitPcg1, 2))
    else $error("clock enable changed without a write");

  unmapped_err_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    setupPh && !hitAny |=> pready && pslverr && (prdata == 32'h0))
    else $error("unmapped access not flagged");

  ready_follows_setup_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    afterFirst |-> (pready == $past(setupPh)))
    else $error("ready not exactly one cycle after setup");

  timer_held_reset_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !pe1[pecg_pkg::TMR0_BIT] [*2] |-> !timerRstN[0])
    else $error("timer 0 left reset while disabled");

  ro_bits_stored_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (pe1[3:0] == 4'hf) && (pcg1[3:0] == 4'hf))
    else $error("read-only low bits of group one lost");

  unmapped_wr_kept_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    psel && penable && pready && pwrite && !hitAny
    |=> $stable(pe1) && $stable(pe2) && $stable(pcg1))
    else $error("unmapped write changed a register");

endmodule
`default_nettype wire

// ---- pecg_testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  //----------------------------------------------------------
  // clock, reset and ports
  //----------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  timerRstN;
  logic [3:0]  ioPortRstN;
  logic        dmaRstN;
  logic        syncSerialRstN;
  logic        twoWireRstN;
  logic [1:0]  serialRstN;
  logic        motorPulseRstN;
  logic [1:0]  converterRstN;
  logic [5:0]  timerClkEn;
  logic [3:0]  ioPortClkEn;
  logic        dmaClkEn;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [31:0] exp1;
  logic [31:0] exp2;
  logic [31:0] expC;

  always #12.5 sys_clk = ~sys_clk;

  pecg_top i_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timerRstN(timerRstN),
    .ioPortRstN(ioPortRstN), .dmaRstN(dmaRstN),
    .syncSerialRstN(syncSerialRstN), .twoWireRstN(twoWireRstN),
    .serialRstN(serialRstN), .motorPulseRstN(motorPulseRstN),
    .converterRstN(converterRstN), .timerClkEn(timerClkEn),
    .ioPortClkEn(ioPortClkEn), .dmaClkEn(dmaClkEn)
  );

  //----------------------------------------------------------
  // helpers
  //----------------------------------------------------------
  task automatic print_verdict();
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // outputs follow register bits one flop later
  task automatic chk_outs();
    chk({timerRstN, ioPortRstN, dmaRstN},
        {exp1[25:24], exp1[19:16], exp1[11:8], exp1[4]});
    chk({converterRstN, motorPulseRstN, serialRstN, twoWireRstN,
         syncSerialRstN},
        {exp2[21:20], exp2[16], exp2[9:8], exp2[4], exp2[0]});
    chk({timerClkEn, ioPortClkEn, dmaClkEn},
        {expC[25:24], expC[19:16], expC[11:8], expC[4]});
  endtask

  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    chk({31'h0, err}, 32'h0);
    #1;
    chk_outs();
    if (a == pecg_pkg::PE1_ADDR) exp1 = (d & 32'h030f_0f10) | 32'hf;
    if (a == pecg_pkg::PE2_ADDR) exp2 = d & 32'h0031_0311;
    if (a == pecg_pkg::PCG1_ADDR) expC = (d & 32'h030f_0f10) | 32'hf;
    @(posedge sys_clk);
    #1;
    chk_outs();
  endtask

  task automatic reg_read(input logic [31:0] a, input logic [31:0] e,
                          input logic eErr);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, e);
    chk({31'h0, err}, {31'h0, eErr});
  endtask

  //----------------------------------------------------------
  // scenarios
  //----------------------------------------------------------
  task automatic test_reset();
    chk_outs();
    reg_read(pecg_pkg::PE1_ADDR, 32'h0000_000f, 1'b0);
    reg_read(pecg_pkg::PE2_ADDR, 32'h0000_0101, 1'b0);
    reg_read(pecg_pkg::PCG1_ADDR, 32'h0000_000f, 1'b0);
  endtask

  task automatic test_enable1();
    reg_write(pecg_pkg::PCG1_ADDR, 32'h030f_0f10);
    reg_write(pecg_pkg::PE1_ADDR, 32'hffff_fff0);
    reg_read(pecg_pkg::PE1_ADDR, 32'h030f_0f1f, 1'b0);
    reg_write(pecg_pkg::PE1_ADDR, 32'h0000_0000);
    reg_read(pecg_pkg::PE1_ADDR, 32'h0000_000f, 1'b0);
  endtask

  task automatic test_enable2();
    int pos[7] = '{0, 4, 8, 9, 16, 20, 21};
    foreach (pos[i]) begin
      reg_write(pecg_pkg::PE2_ADDR, 32'h1 << pos[i]);
      reg_read(pecg_pkg::PE2_ADDR, 32'h1 << pos[i], 1'b0);
    end
    reg_write(pecg_pkg::PE2_ADDR, 32'h0030_0200);
    reg_read(pecg_pkg::PE2_ADDR, 32'h0030_0200, 1'b0);
    reg_write(pecg_pkg::PE2_ADDR, 32'hffff_ffff);
    reg_read(pecg_pkg::PE2_ADDR, 32'h0031_0311, 1'b0);
    reg_write(pecg_pkg::PE2_ADDR, 32'h0000_0000);
  endtask

  task automatic test_gate();
    reg_write(pecg_pkg::PCG1_ADDR, 32'hffff_ffff);
    reg_read(pecg_pkg::PCG1_ADDR, 32'h030f_0f1f, 1'b0);
    reg_write(pecg_pkg::PCG1_ADDR, 32'h0102_0400);
    reg_read(pecg_pkg::PCG1_ADDR, 32'h0102_040f, 1'b0);
  endtask

  // unmapped neighbours must not disturb the mapped registers
  task automatic test_unmapped();
    logic [31:0] rd;
    logic        err;
    apb(1'b1, 32'h4000_0034, 32'hffff_ffff, rd, err);
    chk({31'h0, err}, 32'h1);
    reg_read(32'h4000_0024, 32'h0000_0000, 1'b1);
    #1;
    chk_outs();
    reg_read(pecg_pkg::PE2_ADDR, exp2, 1'b0);
  endtask

  //----------------------------------------------------------
  // main sequence and watchdog
  //----------------------------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    exp1 = 32'h0000_000f;
    exp2 = 32'h0000_0101;
    expC = 32'h0000_000f;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
    test_reset();
    test_enable1();
    test_enable2();
    test_gate();
    test_unmapped();
    print_verdict();
  end
endmodule
`default_nettype wire
